// ### pkg/dac_ctrl_defs.vh
// constants for the multichannel converter update control
`ifndef DAC_CTRL_DEFS_VH
`define DAC_CTRL_DEFS_VH
`define CODE_W 16
`define CHAN_MAX 8
`define CHAN_SEL_W 3
`define RANGE_W 3
`define RANGE_BIPOLAR_BIT 2
`define RANGE_U10 3'h0
`define RANGE_U5 3'h1
`define RANGE_U2P5 3'h2
`define RANGE_B10 3'h4
`define RANGE_B5 3'h5
`define RANGE_B2P5 3'h6
`define CODE_ZERO_UNI 16'h0000
`define CODE_ZERO_BIP 16'h8000
`define TRIM_W 8
`define TRIM_ADDR_W 4
`define TRIM_WORDS 16
`define TRIM_ZERO 8'h00
`define TRIM_FIRST 4'h0
`define TRIM_LAST 4'hF
`define TRIM_STEP 4'h1
`define ST_IDLE 2'h0
`define ST_ADDR 2'h1
`define ST_DATA 2'h2
`define ST_DONE 2'h3
`endif

// ### rtl/dac_channel.v
// one converter channel: range select, staging latch and output latch
`include "dac_ctrl_defs.vh"
module dac_channel (
  input wire clk,
  input wire resetn,
  input wire codeWrite,
  input wire rangeWrite,
  input wire [`CODE_W-1:0] wrData,
  input wire [`RANGE_W-1:0] wrRange,
  input wire selfUpdate,
  input wire globalUpdate,
  output reg [`CODE_W-1:0] outCode_reg,
  output reg [`RANGE_W-1:0] range_reg,
  output reg [`CODE_W-1:0] stage_reg
);
  // zero volts depends on the coding of the selected range
  wire [`CODE_W-1:0] zeroCode = wrRange[`RANGE_BIPOLAR_BIT] ? `CODE_ZERO_BIP : `CODE_ZERO_UNI;
  // range change reloads both latches with that range's zero-volt code so no glitch appears
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      range_reg <= `RANGE_U10;
      stage_reg <= `CODE_ZERO_UNI;
      outCode_reg <= `CODE_ZERO_UNI;
    end else begin
      if (rangeWrite) begin
        range_reg <= wrRange;
        stage_reg <= zeroCode;
        outCode_reg <= zeroCode;
      end else begin
        if (codeWrite)
          stage_reg <= wrData;
        // the write in the same cycle is forwarded so independent mode shows the new code at once
        if (selfUpdate && codeWrite)
          outCode_reg <= wrData;
        else if (globalUpdate)
          outCode_reg <= codeWrite ? wrData : stage_reg;
      end
    end
  end
endmodule

// ### rtl/multichannel_dac_update_control.v
// top of the multichannel converter update control with calibration trim loader
// How it works
// - the build option NUM_CHAN gives two, four or eight channels, each taking a 16-bit code.
// - each channel has its own latches and converter outputs, written by its own strobes and by the shared simultaneous update.
// - each channel keeps its own range among three unipolar and three bipolar spans.
// - each channel has a staging latch loaded by host writes and an output latch feeding the converter.
// - a mode bit selects per-channel immediate updates or a common simultaneous update.
// - reset loads every latch, and a range change both latches of its channel, with the zero-volt code of the range.
// - codes arrive as single programmed writes, one word per strobe, with no burst or DMA path.
// - after reset the trim values are read from nonvolatile memory and drive the trim converters.
`include "dac_ctrl_defs.vh"
module multichannel_dac_update_control #(
  parameter NUM_CHAN = 8
) (
  input wire clk,
  input wire resetn,
  input wire codeWrite,
  input wire rangeWrite,
  input wire [`CHAN_SEL_W-1:0] wrChan,
  input wire [`CODE_W-1:0] wrData,
  input wire [`RANGE_W-1:0] wrRange,
  input wire simulMode,
  input wire updateAll,
  input wire calReload,
  input wire [`TRIM_W-1:0] nvmData,
  input wire nvmValid,
  output reg nvmRead_reg,
  output reg [`TRIM_ADDR_W-1:0] nvmAddr_reg,
  output reg calDone_reg,
  output wire [NUM_CHAN*`CODE_W-1:0] dacCode,
  output wire [NUM_CHAN*`RANGE_W-1:0] dacRange,
  output reg [`TRIM_WORDS*`TRIM_W-1:0] trimCode_reg
);
  // channel decode: a write to a channel number above the build's count matches no
  // channel and is dropped, so software written for a larger build cannot wrap around
  wire [NUM_CHAN-1:0] chanHit;
  // update controls are shared by every channel; only the write strobes are steered
  wire selfUpdate = !simulMode;
  wire globalUpdate = simulMode && updateAll;
  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g = g + 1) begin : chan
      // channel number at the width of the select bus
      localparam [`CHAN_SEL_W-1:0] CHAN_ID = g;
      assign chanHit[g] = (wrChan == CHAN_ID);
      dac_channel u_ch (
        .clk(clk),
        .resetn(resetn),
        .codeWrite(codeWrite && chanHit[g]),
        .rangeWrite(rangeWrite && chanHit[g]),
        .wrData(wrData),
        .wrRange(wrRange),
        .selfUpdate(selfUpdate),
        .globalUpdate(globalUpdate),
        .outCode_reg(dacCode[g*`CODE_W +: `CODE_W]),
        .range_reg(dacRange[g*`RANGE_W +: `RANGE_W]),
        .stage_reg() // staged codes are not brought out
      );
    end
  endgenerate

  // trim loader states, binary coded
  localparam [1:0] LOAD_IDLE = `ST_IDLE;
  localparam [1:0] LOAD_ADDR = `ST_ADDR;
  localparam [1:0] LOAD_DATA = `ST_DATA;
  localparam [1:0] LOAD_DONE = `ST_DONE;

  // trim loader: reads every word of nonvolatile memory in address order, one request
  // outstanding at a time; the memory may take any number of cycles to answer, so a
  // memory that never answers leaves the done flag low and the trims at zero, or at the old factors after a reload
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg startPend_reg;
  wire loadStart = (state_reg == LOAD_IDLE) && startPend_reg;
  wire wordTaken = (state_reg == LOAD_DATA) && nvmValid;
  wire lastWord = (nvmAddr_reg == `TRIM_LAST);
  wire passEnd = (state_reg == LOAD_DONE);

  // next state of the trim loader
  always @* begin
    state_next = state_reg;
    case (state_reg)
      LOAD_IDLE: begin
        // a pending start, from reset or from a reload, opens a new pass
        if (startPend_reg)
          state_next = LOAD_ADDR;
      end
      LOAD_ADDR: begin
        // one cycle for the address to settle before the read is raised
        state_next = LOAD_DATA;
      end
      LOAD_DATA: begin
        // hold the read until the memory answers
        if (nvmValid) begin
          if (lastWord)
            state_next = LOAD_DONE;
          else
            state_next = LOAD_ADDR;
        end
      end
      LOAD_DONE: begin
        state_next = LOAD_IDLE;
      end
      default: begin
        state_next = LOAD_IDLE;
      end
    endcase
  end

  // state register of the trim loader
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= LOAD_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // start request, set by reset and by each reload pulse and cleared when a pass opens;
  // a reload during a pass is kept and runs a fresh pass once this one ends
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      startPend_reg <= 1'b1;
    end else if (calReload) begin
      startPend_reg <= 1'b1; // the set wins over a clear in the same cycle
    end else if (loadStart) begin
      startPend_reg <= 1'b0;
    end
  end

  // read request, taken from the next state so the pin comes straight from a flip-flop
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nvmRead_reg <= 1'b0;
    end else begin
      nvmRead_reg <= (state_next == LOAD_DATA);
    end
  end

  // word address: back to the first word at each pass, one step per answered read
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nvmAddr_reg <= `TRIM_FIRST;
    end else if (loadStart) begin
      nvmAddr_reg <= `TRIM_FIRST;
    end else if (wordTaken) begin
      nvmAddr_reg <= nvmAddr_reg + `TRIM_STEP;
    end
  end

  // one load enable per trim word; a decoder per slot is cheaper than a variable-index write
  wire [`TRIM_WORDS-1:0] trimLoad;
  genvar t;
  generate
    for (t = 0; t < `TRIM_WORDS; t = t + 1) begin : trim
      localparam [`TRIM_ADDR_W-1:0] WORD_ID = t;
      assign trimLoad[t] = wordTaken && (nvmAddr_reg == WORD_ID);
    end
  endgenerate

  // trim words hold zero until the stored factors arrive; a reload rewrites them in place,
  // so the converters keep the old factors until each new word lands
  integer i;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trimCode_reg <= {`TRIM_WORDS{`TRIM_ZERO}};
    end else begin
      for (i = 0; i < `TRIM_WORDS; i = i + 1) begin
        if (trimLoad[i])
          trimCode_reg[i*`TRIM_W +: `TRIM_W] <= nvmData;
      end
    end
  end

  // done flag: low for the whole pass, high from the cycle after the last word lands
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      calDone_reg <= 1'b0;
    end else if (loadStart) begin
      calDone_reg <= 1'b0;
    end else if (passEnd) begin
      calDone_reg <= 1'b1;
    end
  end
endmodule

// ### bench/nvm_model.sv
// trim memory model: one word per read request
module nvm_model (
  input wire logic clk, resetn, nvmRead_reg,
  input wire logic [3:0] nvmAddr_reg,
  output logic [7:0] nvmData,
  output logic nvmValid
);
  timeunit 1ns;
  timeprecision 1ns;
  // answer a cycle late; data is scrambled while not valid
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nvmValid <= 1'b0;
      nvmData <= 8'hFF;
    end else begin
      nvmValid <= nvmRead_reg && !nvmValid;
      nvmData <= (nvmRead_reg && !nvmValid) ? {4'h5, nvmAddr_reg} : ~nvmData;
    end
  end
endmodule

// ### bench/dac_upd_checker.sv
// port assertions for the update control
module dac_upd_checker #(parameter NUM_CHAN = 8) (
  input wire clk, resetn, codeWrite, rangeWrite, simulMode, updateAll, calReload,
  input wire nvmValid, nvmRead_reg, calDone_reg,
  input wire [2:0] wrChan, wrRange,
  input wire [15:0] wrData,
  input wire [7:0] nvmData,
  input wire [3:0] nvmAddr_reg,
  input wire [NUM_CHAN*16-1:0] dacCode,
  input wire [NUM_CHAN*3-1:0] dacRange,
  input wire [127:0] trimCode_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence sTake; !simulMode && codeWrite && !rangeWrite && wrChan == 3'h0; endsequence
  sequence sStage; simulMode && !updateAll && !rangeWrite; endsequence
  sequence sRange; rangeWrite && wrChan == 3'h0; endsequence
  code_take_a: assert property (sTake |=> dacCode[15:0] == $past(wrData))
    else $error("code not taken");
  staged_hold_a: assert property (sStage |=> $stable(dacCode))
    else $error("output moved");
  range_zero_a: assert property (sRange |=> dacCode[15:0] == {$past(wrRange[2]), 15'h0})
    else $error("bad zero code");
  range_set_a: assert property (sRange |=> dacRange[2:0] == $past(wrRange))
    else $error("range lost");
  other_chan_a: assert property (codeWrite && wrChan == 3'h1 && !updateAll |=>
    $stable(dacCode[15:0])) else $error("channel disturbed");
  bad_chan_a: assert property ((codeWrite || rangeWrite) && wrChan >= NUM_CHAN
    && !updateAll |=> $stable(dacCode)) else $error("bad channel taken");
  cal_idle_a: assert property (calDone_reg |-> !nvmRead_reg)
    else $error("read after done");
  trim_keep_a: assert property (nvmRead_reg && nvmValid && nvmAddr_reg == 4'h0 |=>
    trimCode_reg[7:0] == $past(nvmData)) else $error("trim lost");
endmodule

// ### bench/test_multichannel_dac_update_control.sv
// bench top for the update control
module test_multichannel_dac_update_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, resetn = 0, codeWrite = 0, rangeWrite = 0, simulMode = 0, updateAll = 0;
  logic calReload = 0, nvmValid, nvmRead_reg, calDone_reg;
  logic [2:0] wrChan = 0, wrRange = 0;
  logic [15:0] wrData = 0;
  logic [7:0] nvmData;
  logic [3:0] nvmAddr_reg;
  logic [63:0] dacCode;
  logic [11:0] dacRange;
  logic [127:0] trimCode_reg;
  int num_errors = 0, checks_done = 0, cyc = 0;
  // rows: channel, code, expected output
  logic [34:0] rows [3] = '{{3'h0, 16'hFFFF, 16'hFFFF}, {3'h3, 16'h0001, 16'h0001},
    {3'h1, 16'h8000, 16'h8000}};
  multichannel_dac_update_control #(.NUM_CHAN(4)) dut (.*);
  nvm_model mem (.*);
  initial forever #5 clk = ~clk;
  task chk(input logic [15:0] g, e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  // wait for the trim pass to finish, bounded
  task waitDone;
    for (int j = 0; j < 300 && calDone_reg !== 1'b1; j++) @(posedge clk);
    #1;
  endtask
  // every trim word against the pattern that the memory model serves
  task chkTrims;
    for (int j = 0; j < 16; j++) chk({8'h0, trimCode_reg[8*j+:8]}, {12'h5, j[3:0]});
  endtask
  task wr(input logic c, r, input logic [2:0] ch, input logic [15:0] d);
    @(posedge clk);
    {codeWrite, rangeWrite, wrChan, wrData, wrRange} <= {c, r, ch, d, d[2:0]};
    @(posedge clk);
    {codeWrite, rangeWrite} <= 2'h0;
    #1;
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // cycle ceiling against a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      $display("mismatch %0t cycle limit reached", $time);
      end_of_test;
    end
  end
  initial begin
    int k;
    repeat (5) @(posedge clk);
    resetn <= 1;
    #1 chk(dacCode[63:48], 16'h0000);
    for (k = 0; k < 3; k++) begin
      wr(1, 0, rows[k][34:32], rows[k][31:16]);
      chk(dacCode[rows[k][34:32]*16+:16], rows[k][15:0]);
    end
    wr(1, 0, 3'h5, 16'hBEEF);
    chk(dacCode[15:0], 16'hFFFF);
    wr(0, 1, 3'h0, 16'h0005);
    chk(dacCode[15:0], 16'h8000);
    chk({13'h0, dacRange[2:0]}, 16'h0005);
    @(posedge clk) simulMode <= 1;
    wr(1, 0, 3'h2, 16'hA5A5);
    chk(dacCode[47:32], 16'h0000);
    @(posedge clk) updateAll <= 1;
    @(posedge clk) updateAll <= 0;
    #1 chk(dacCode[47:32], 16'hA5A5);
    // range and code strobed together: the range wins and clears to bipolar zero
    wr(1, 1, 3'h3, 16'h0004);
    chk(dacCode[63:48], 16'h8000);
    chk({13'h0, dacRange[11:9]}, 16'h0004);
    waitDone;
    chk({14'h0, calDone_reg, nvmRead_reg}, 16'h0002);
    chk({12'h0, nvmAddr_reg}, 16'h0000);
    chkTrims;
    // reload: done drops and the read is raised again, then the set is read anew
    @(posedge clk) calReload <= 1;
    @(posedge clk) calReload <= 0;
    repeat (2) @(posedge clk);
    #1 chk({14'h0, calDone_reg, nvmRead_reg}, 16'h0001);
    waitDone;
    chkTrims;
    // second reset in mid-run: latches back to zero volts, trims cleared and reloaded
    @(posedge clk) resetn <= 0;
    @(posedge clk) resetn <= 1;
    #1 chk(dacCode[15:0] | dacCode[31:16] | dacCode[47:32] | dacCode[63:48], 16'h0000);
    chk({4'h0, dacRange}, 16'h0000);
    chk({15'h0, calDone_reg}, 16'h0000);
    chk(trimCode_reg[15:0], 16'h0000);
    // first write after release, forwarded by an update in the same cycle
    @(posedge clk) {codeWrite, wrChan, wrData, updateAll} <= {1'b1, 3'h1, 16'h1234, 1'b1};
    @(posedge clk) {codeWrite, updateAll} <= 2'h0;
    #1 chk(dacCode[31:16], 16'h1234);
    waitDone;
    chkTrims;
    end_of_test;
  end
endmodule
bind multichannel_dac_update_control dac_upd_checker #(.NUM_CHAN(NUM_CHAN)) chk_i (.*);
